// ### hw/output_group_skew_control.sv
// output group source routing, per-output enable, phase and time skew
// Behaviour
// R1: adjacent banks pair into groups, five for ten banks and three for six, sharing one routing connection.
// R2: both outputs of a group always take the same single source, one divider or one reference.
// R3: each output is enabled alone by stored configuration, user pins or bus commands.
// R4: phase skew acts only on divider-sourced outputs while the PLL is active.
// R5: time skew is available on every output whatever its source.
// R6: each output has sixteen phase skew settings and sixteen time skew settings.
// R7: each output, both of a group too, takes its own phase skew of zero to fifteen units.
// R8: the phase unit is one eighth VCO period in fine mode and one quarter in coarse mode.
// R9: coarse mode inserts a divide-by-two stage ahead of the whole divider bank.
// R10: when going to coarse mode software moves feedback to the next lower divider.
// R11: in bypass all phase skew is ignored, only time skew and path delay remain.
// R12: time skew adds on top of the selected phase skew.
// R13: the time skew step is fixed and independent of the VCO rate.
// R14: bypass routes the reference into the dividers and disables lock detect and phase skew.
// R15: dividers divide by 2, 4, 8, 16 in fine mode and 4, 8, 16, 32 in coarse mode.
// R16: phase skew delays the divided clock by counted unit ticks from the VCO, halved in coarse mode.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module output_group_skew_control #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic        ref_a,
  input  wire logic        ref_b,
  input  wire logic        user_bypass,
  input  wire logic [9:0]  user_en,
  output logic      [9:0]  clk_out,
  output logic             lock_detect_en
);

  // --- input synchronisers: three flops, accepted once stages two and three agree
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic [12:0] sync3;
  logic [12:0] filt;
  logic [12:0] pins_raw;

  assign pins_raw = {user_bypass, user_en, ref_b, ref_a};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt  <= '0;
    end
    else
    begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= ((sync2 ^ sync3) & filt) | (~(sync2 ^ sync3) & sync3);
    end
  end

  logic       ref_a_s;
  logic       ref_b_s;
  logic       bypass_pin_s;
  logic [9:0] en_pin_s;

  assign ref_a_s      = filt[0];
  assign ref_b_s      = filt[1];
  assign en_pin_s     = filt[11:2];
  assign bypass_pin_s = filt[12];

  // --- registers
  logic [1:0]  ctrl;
  logic [14:0] group_src;
  logic [9:0]  out_en;
  logic [3:0]  phase_set [skew_pkg::NUM_BANKS];
  logic [3:0]  time_set  [skew_pkg::NUM_BANKS];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl      <= skew_pkg::CTRL_RESET;
      group_src <= skew_pkg::SRC_RESET;
      out_en    <= skew_pkg::NV_EN_RESET; // [R3]
    end
    else if (wr_stb)
    begin
      if (addr == skew_pkg::ADDR_CTRL)
        ctrl <= wdata[1:0];
      if (addr == skew_pkg::ADDR_SRC)
        group_src <= wdata[14:0]; // one code per group, so a group never mixes sources [R2]
      if (addr == skew_pkg::ADDR_EN)
        out_en <= wdata[9:0]; // [R3]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < skew_pkg::NUM_BANKS; i++)
      begin
        phase_set[i] <= '0;
        time_set[i]  <= '0;
      end
    end
    else if (wr_stb)
    begin
      for (int i = 0; i < skew_pkg::NUM_BANKS; i++)
      begin
        if (addr == skew_pkg::ADDR_SKEW0 + 8'(i))
        begin
          phase_set[i] <= wdata[skew_pkg::SKEW_PH_LSB +: skew_pkg::SKEW_W]; // own value per output [R7]
          time_set[i]  <= wdata[skew_pkg::SKEW_TM_LSB +: skew_pkg::SKEW_W]; // [R6]
        end
      end
    end
  end

  // --- mode
  logic bypass;
  logic coarse;

  assign bypass = ctrl[skew_pkg::CTRL_BYPASS] | bypass_pin_s; // register or user pin
  assign coarse = ctrl[skew_pkg::CTRL_COARSE];
  // lock detect is meaningless with the loop bypassed
  assign lock_detect_en = ~bypass; // [R14]

  // --- divider bank input: core_clk stands in for the vco, the reference in bypass
  logic ref_sel_prev;
  logic ref_edge;
  logic feed_tick;
  logic half_phase;
  logic div_tick;
  logic unit_tick;
  logic [3:0] div_cnt;
  logic [3:0] div_clk;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ref_sel_prev <= 1'b0;
    else
      ref_sel_prev <= ref_a_s;
  end

  assign ref_edge  = ref_a_s & ~ref_sel_prev;
  assign feed_tick = bypass ? ref_edge : 1'b1; // [R14]

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      half_phase <= 1'b0;
    else if (feed_tick)
      half_phase <= ~half_phase;
  end

  // coarse mode halves the rate before every divider; software must retune feedback [R9] [R10]
  assign div_tick  = feed_tick & (~coarse | half_phase); // [R9]
  // phase unit: every vco tick in fine, every second in coarse, keeping the 1:2 ratio [R8] [R16]
  assign unit_tick = ~bypass & (~coarse | half_phase); // [R8]

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= '0;
    else if (div_tick)
      div_cnt <= div_cnt + 4'h1;
  end

  // counter bit k toggles every 2^k ticks: divide by 2, 4, 8, 16 of the tick [R15]
  assign div_clk = div_cnt;

  // --- per output path
  logic [9:0] path_out;

  genvar gi;
  generate
    for (gi = 0; gi < skew_pkg::NUM_BANKS; gi++)
    begin : g_out
      localparam int GRP = gi / 2; // banks 2g and 2g+1 share group g [R1]
      logic [2:0]  src;
      logic        raw;
      logic        phase_ok;
      logic [15:0] ph_line;
      logic [15:0] tm_line;
      logic        ph_out;
      logic        tm_out;
      logic        present;

      assign src = group_src[GRP * skew_pkg::SRC_W +: skew_pkg::SRC_W]; // [R1]
      assign raw = (src <= skew_pkg::SRC_DIV_LAST) ? div_clk[src[1:0]] :
                   (src == skew_pkg::SRC_REF_A) ? ref_a_s :
                   (src == skew_pkg::SRC_REF_B) ? ref_b_s : 1'b0; // [R2]
      // phase skew only for divider sources with the loop active [R4] [R11]
      assign phase_ok = (src <= skew_pkg::SRC_DIV_LAST) & ~bypass; // [R4]

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          ph_line <= '0;
        else if (unit_tick)
          ph_line <= {ph_line[14:0], raw}; // [R16]
      end

      // zero to fifteen unit delays [R7]
      assign ph_out = (!phase_ok || phase_set[gi] == 4'h0) ? raw : ph_line[phase_set[gi] - 4'h1]; // [R11]

      // delay line counted in core cycles, so the step ignores the vco rate [R13]
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          tm_line <= '0;
        else
          tm_line <= {tm_line[14:0], ph_out}; // fed after phase skew [R12]
      end

      assign tm_out = (time_set[gi] == 4'h0) ? ph_out : tm_line[time_set[gi] - 4'h1]; // every source [R5]

      // the six-bank variant has only three groups [R1]
      assign present = !SMALL_VARIANT || (GRP < skew_pkg::SMALL_GROUPS);

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          path_out[gi] <= 1'b0;
        else
          path_out[gi] <= tm_out & out_en[gi] & en_pin_s[gi] & present; // [R3]
      end
    end
  endgenerate

  assign clk_out = path_out;

  // --- read port, data one cycle after the strobe; unmapped reads zero
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = '0;
    if (addr == skew_pkg::ADDR_CTRL)
      next_rdata[1:0] = ctrl;
    else if (addr == skew_pkg::ADDR_SRC)
      next_rdata[14:0] = group_src;
    else if (addr == skew_pkg::ADDR_EN)
      next_rdata[9:0] = out_en;
    else if (addr == skew_pkg::ADDR_STATUS)
    begin
      next_rdata[skew_pkg::ST_BYPASS] = bypass;
      next_rdata[skew_pkg::ST_COARSE] = coarse;
      next_rdata[skew_pkg::ST_DIV_LSB +: skew_pkg::NUM_DIVS] = div_clk;
      next_rdata[skew_pkg::ST_OUT_LSB +: skew_pkg::NUM_BANKS] = path_out;
    end
    else
    begin
      for (int i = 0; i < skew_pkg::NUM_BANKS; i++)
      begin
        if (addr == skew_pkg::ADDR_SKEW0 + 8'(i))
          next_rdata[7:0] = {time_set[i], phase_set[i]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd_stb)
      rdata <= next_rdata;
    else
      rdata <= '0;
  end

endmodule

// ### hw/skew_pkg.sv
// constants shared by the output group skew control block
package skew_pkg;
  localparam int NUM_BANKS   = 10;
  localparam int NUM_GROUPS  = 5;
  localparam int SMALL_GROUPS = 3;
  localparam int NUM_DIVS    = 4;
  localparam int SKEW_W      = 4;
  localparam int SKEW_STEPS  = 16;
  localparam int SRC_W       = 3;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int SYNC_W      = 13;

  // source codes of one output group
  localparam logic [2:0] SRC_DIV_LAST = 3'h3;
  localparam logic [2:0] SRC_REF_A    = 3'h4;
  localparam logic [2:0] SRC_REF_B    = 3'h5;

  // register word addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_SRC     = 8'h01;
  localparam logic [7:0] ADDR_EN      = 8'h02;
  localparam logic [7:0] ADDR_STATUS  = 8'h03;
  localparam logic [7:0] ADDR_SKEW0   = 8'h10;

  // field positions
  localparam int CTRL_BYPASS  = 0;
  localparam int CTRL_COARSE  = 1;
  localparam int SKEW_PH_LSB  = 0;
  localparam int SKEW_TM_LSB  = 4;
  localparam int ST_BYPASS    = 0;
  localparam int ST_COARSE    = 1;
  localparam int ST_DIV_LSB   = 4;
  localparam int ST_OUT_LSB   = 8;

  // reset values
  localparam logic [1:0]  CTRL_RESET = 2'h0;
  localparam logic [14:0] SRC_RESET  = 15'h0000;
  localparam logic [9:0]  NV_EN_RESET = 10'h3FF;
endpackage

// ### tb/clock_load.sv
// board loads: count rising edges arriving on each output clock
`timescale 1ns/1ps
module clock_load (
  input  wire logic             core_clk,
  input  wire logic             clr,
  input  wire logic [9:0]       clk_out,
  output logic      [9:0][15:0] edges
);
  logic [9:0] last;
  always_ff @(posedge core_clk)
  begin
    last <= clk_out;
    for (int i = 0; i < 10; i++)
      edges[i] <= clr ? 16'h0 : edges[i] + 16'(clk_out[i] & ~last[i]);
  end
endmodule

// ### tb/skew_properties.sv
// port checker for the output group skew control block
`timescale 1ns/1ps
module skew_properties (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [9:0]  clk_out,
  input wire logic        lock_detect_en
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence wr_en; wr_stb && addr == skew_pkg::ADDR_EN; endsequence
  sequence rd_en; rd_stb && addr == skew_pkg::ADDR_EN; endsequence
  sequence wr_ctl; wr_stb && addr == skew_pkg::ADDR_CTRL; endsequence
  sequence rd_st; rd_stb && addr == skew_pkg::ADDR_STATUS; endsequence
  sequence wr_skw; wr_stb && addr >= skew_pkg::ADDR_SKEW0 && addr < 8'h1A; endsequence
  a_rdata_idle: assert property (!rd_stb |=> rdata == 32'h0) else $error("rdata not idle");
  a_unmapped_zero: assert property (rd_stb && addr inside {[8'h04:8'h0F]} |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_en_readback: assert property (wr_en ##1 rd_en |=> rdata == {22'h0, $past(wdata[9:0], 2)})
    else $error("enable readback wrong");
  a_skew_readback: assert property (wr_skw ##1 (rd_stb && addr == $past(addr))
    |=> rdata == {24'h0, $past(wdata[7:0], 2)}) else $error("skew readback wrong");
  a_bypass_lock: assert property (wr_ctl ##0 wdata[skew_pkg::CTRL_BYPASS] |=> !lock_detect_en)
    else $error("lock detect left on in bypass");
  a_status_bypass: assert property (rd_st |=> rdata[0] == !$past(lock_detect_en))
    else $error("status bypass wrong");
  a_coarse_status: assert property (wr_ctl ##1 rd_st |=> rdata[1] == $past(wdata[1], 2))
    else $error("status coarse wrong");
  a_disable_out: assert property (wr_en ##0 wdata[9:0] == 10'h0 |=> ##2 clk_out == 10'h0)
    else $error("disabled outputs still run");
endmodule
bind output_group_skew_control skew_properties i_props (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .clk_out(clk_out), .lock_detect_en(lock_detect_en));

// ### tb/testbench.sv
// self-checking bench for the output group skew control block
`timescale 1ns/1ps
module testbench;
  logic             core_clk, rst_n, wr_stb, rd_stb, user_bypass, lock_detect_en, clr;
  logic             ref_a = 1'b0, ref_b = 1'b0;
  logic [7:0]       addr;
  logic [31:0]      wdata, rdata, got, srcv;
  logic [7:0]       reset_addr [5] = '{8'h00, 8'h01, 8'h02, 8'h19, 8'h04};
  logic [9:0]       user_en, clk_out, hist [64];
  logic [9:0][15:0] edges;
  int               bad_count, checks_done, cyc, a, b, ti, tj, u;
  output_group_skew_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ref_a(ref_a), .ref_b(ref_b), .user_bypass(user_bypass),
    .user_en(user_en), .clk_out(clk_out), .lock_detect_en(lock_detect_en));
  clock_load i_load (.core_clk(core_clk), .clr(clr), .clk_out(clk_out), .edges(edges));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // references are slow and unrelated in period so a wrong source shows up as a wrong edge count
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    ref_a <= cyc % 12 < 6;
    ref_b <= cyc % 20 < 10;
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // a write keeps its strobe until the next access, which makes write then read back to back
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    addr <= ad;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge core_clk);
    addr <= ad;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(negedge core_clk);
    got = rdata;
  endtask
  task automatic count(input int w);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (w) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // the outputs carry an unknown fixed path delay, so only the relative lag of two outputs is judged
  task automatic lag(input int i, input int j, input int d);
    int n;
    int c;
    n = 0;
    c = 0;
    repeat (100) @(posedge core_clk);
    for (int k = 0; k < 64; k++)
    begin
      @(negedge core_clk);
      hist[k] = clk_out;
    end
    for (int k = d + 1; k < 64; k++)
    begin
      n += int'(hist[k][j] !== hist[k - d][i]);
      c += int'(hist[k][j] !== hist[k - 1][j]);
    end
    cmp("lag", 32'h0, n + int'(c == 0));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial
  begin
    {rst_n, wr_stb, rd_stb, user_bypass, clr, addr, wdata} = '0;
    user_en = 10'h3FF;
    void'($urandom(68969));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (reset_addr[q])
    begin
      rd(reset_addr[q]);
      cmp("reset value", q == 2 ? 32'h3FF : 32'h0, got);
    end
    $display("test reset done");
    // modes: fine divider, coarse divider, reference source, bypass; phase unit 1, 2, none, none
    for (int m = 0; m < 4; m++)
    begin
      u = m < 2 ? m + 1 : 0;
      wr(skew_pkg::ADDR_CTRL, {30'h0, m == 1, m == 3}); // feedback move is the configurer's part
      rd(skew_pkg::ADDR_STATUS);
      cmp("lock", m != 3, lock_detect_en);
      cmp("status mode", {30'h0, m == 1, m == 3}, 32'(got[1:0]));
      // divider 3 outlasts the longest lag so a wrong lag cannot alias; ref-fed dividers are slow, so bypass uses 0
      srcv = m == 2 ? {29'h0, skew_pkg::SRC_REF_A} : (m < 2 ? 32'h3 : 32'h0);
      wr(skew_pkg::ADDR_SRC, srcv);
      rd(skew_pkg::ADDR_SRC);
      cmp("source", srcv, got);
      a = $urandom % 8;
      b = a + $urandom % 8;
      ti = $urandom % 8;
      tj = ti + $urandom % 8;
      wr(skew_pkg::ADDR_SKEW0, 32'(ti * 16 + a));
      rd(skew_pkg::ADDR_SKEW0);
      cmp("skew", 32'(ti * 16 + a), got);
      wr(8'h11, 32'(tj * 16 + b));
      rd(8'h11);
      cmp("skew", 32'(tj * 16 + b), got);
      lag(0, 1, tj - ti + u * (b - a));
      for (int k = 0; k < 4 && m < 2; k++)
      begin
        wr(skew_pkg::ADDR_SRC, 32'(k * 4680));
        rd(skew_pkg::ADDR_SRC);
        cmp("source", 32'(k * 4680), got);
        count(256);
        for (int o = 2; o < 10; o++)
          cmp("edges", 32'h1, 32'((int'(edges[o]) - (256 >> (k + 1 + m))) inside {[-1:1]}));
      end
      $display("test %0d done", m);
    end
    wr(skew_pkg::ADDR_SRC, 32'(skew_pkg::SRC_REF_B) << 12);
    wr(skew_pkg::ADDR_EN, 32'h3F7);
    rd(skew_pkg::ADDR_EN);
    cmp("enable", 32'h3F7, got);
    // pins pass the synchroniser first, so let them settle before counting
    @(posedge core_clk);
    user_en <= 10'h3EF;
    repeat (8) @(posedge core_clk);
    count(300);
    cmp("off", 32'h0, edges[3] + edges[4]);
    cmp("ref b", 32'h1, 32'((int'(edges[8]) - 15) inside {[-1:1]}));
    wr(skew_pkg::ADDR_EN, 32'h0);
    rd(skew_pkg::ADDR_EN);
    cmp("enable", 32'h0, got);
    wr(skew_pkg::ADDR_CTRL, 32'h0);
    rd(skew_pkg::ADDR_STATUS);
    cmp("lock", 32'h1, lock_detect_en);
    @(posedge core_clk);
    user_bypass <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(skew_pkg::ADDR_STATUS);
    cmp("pin bypass", 32'h1, 32'(got[skew_pkg::ST_BYPASS]));
    cmp("pin bypass", 32'h0, lock_detect_en);
    $display("test 4 done");
    give_verdict();
  end
endmodule
